// [core/bzc_channel_config.sv]
// Purpose: Impedance channel configuration register and its decoded settings
// Assumes: APB master keeps protocol; one clock pclk at 100 MHz
// Notes:   Zero wait-state slave; writes land at the access edge; unmapped gives pslverr
//
// Summary of operation
// R1 - Channel config register at 0x18 is read/write and steers the channel.
// R2 - Any channel config write raises resync need; resync command clears it.
// R3 - Clock select 00: rate bit 0 gives 64 sps, 1 gives 32 sps.
// R4 - Clock select 01: rate bit gives 62.50 or 31.25 sps.
// R5 - Clock select 10: rate bit gives 50 or 25 sps.
// R6 - Clock select 11: rate bit gives 49.95 or 24.98 sps.
// R7 - Analog high-pass code bits 22:20, reset 010; codes 11x bypass.
// R8 - Bit 19 selects internal (0) or external resistor (1) bias.
// R9 - Bit 18 selects amplifier low power (0) or low noise (1).
// R10 - Gain bits 17:16 select 10, 20, 40 or 80 V/V.
// R11 - Digital high-pass 00 bypass, 01 0.05 Hz, 1x 0.50 Hz.
// R12 - Nominal code selects 5000 down to 625 ohms; modulation 1xx unmodulated.
// R13 - Nominal codes 011-111 engage extra switches; modulation code 010 only below.
// R14 - Modulation field bits 6:4 resets 100; reserved 011 never stored.
// R15 - Nominal field bits 10:8 reset 000; applies only with self-test enabled.
// R16 - Reset returns every field to its default before any write.
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
module bzc_channel_config (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  // Decoded channel settings
  output bzc_pkg::bzc_settings_t      settings,
  output logic                        resync_needed
);
  // ******************************************************
  // Register state
  // ******************************************************
  logic [23:0]            chan_reg, chan_next;
  logic [23:0]            mux_reg, mux_next;
  logic [1:0]             mclk_reg, mclk_next;
  logic                   resync_reg, resync_next;
  logic [31:0]            prdata_reg, prdata_next;
  logic                   pslverr_reg, pslverr_next;
  logic                   pready_reg, pready_next;
  bzc_pkg::bzc_settings_t set_reg, set_next;
  logic                   acc;
  logic                   xfer;
  logic                   wr;
  logic                   hit;

  assign acc  = psel && !penable;
  assign xfer = psel && penable && pready_reg;
  assign wr   = xfer && pwrite;

  always_comb begin
    chan_next    = chan_reg;
    mux_next     = mux_reg;
    mclk_next    = mclk_reg;
    resync_next  = resync_reg;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    pready_next  = acc;
    hit          = 1'b1;
    case (paddr)
      bzc_pkg::CHAN_CFG_ADDR: prdata_next = {8'h00, chan_reg};
      bzc_pkg::MUX_CFG_ADDR:  prdata_next = {8'h00, mux_reg};
      bzc_pkg::MCLK_SEL_ADDR: prdata_next = {30'h0, mclk_reg};
      bzc_pkg::RESYNC_ADDR:   prdata_next = {31'h0, resync_reg};
      default: begin
        prdata_next = 32'h0;
        hit         = 1'b0;
      end
    endcase
    if (!acc) begin
      prdata_next = prdata_reg;
    end else begin
      pslverr_next = !hit;
    end
    if (wr && paddr == bzc_pkg::CHAN_CFG_ADDR) begin
      chan_next   = pwdata[23:0] & bzc_pkg::CHAN_CFG_WMASK; // see R1
      resync_next = 1'b1; // see R2
    end
    if (wr && paddr == bzc_pkg::MUX_CFG_ADDR) begin
      mux_next = pwdata[23:0] & bzc_pkg::MUX_CFG_WMASK;
      if (pwdata[bzc_pkg::RMOD_LSB +: 3] == bzc_pkg::RMOD_RESERVED) begin
        mux_next[bzc_pkg::RMOD_LSB +: 3] = mux_reg[bzc_pkg::RMOD_LSB +: 3]; // see R14
      end
    end
    if (wr && paddr == bzc_pkg::MCLK_SEL_ADDR) begin
      mclk_next = pwdata[1:0];
    end
    if (wr && paddr == bzc_pkg::RESYNC_ADDR && pwdata[0]) begin
      resync_next = 1'b0; // see R2
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_reg    <= bzc_pkg::CHAN_CFG_RST; // see R16
      mux_reg     <= bzc_pkg::MUX_CFG_RST; // see R14
      mclk_reg    <= bzc_pkg::MCLK_SEL_RST;
      resync_reg  <= 1'b0;
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
      pready_reg  <= 1'b0;
    end else begin
      chan_reg    <= chan_next;
      mux_reg     <= mux_next;
      mclk_reg    <= mclk_next;
      resync_reg  <= resync_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
      pready_reg  <= pready_next;
    end
  end

  // ******************************************************
  // Field decode
  // ******************************************************
  logic [2:0] rnom;
  logic [2:0] rmod;
  logic       bist_on;
  assign rnom    = mux_reg[bzc_pkg::RNOM_LSB +: 3];
  assign rmod    = mux_reg[bzc_pkg::RMOD_LSB +: 3];
  assign bist_on = mux_reg[bzc_pkg::BIST_BIT];

  always_comb begin
    set_next = '0;
    case ({mclk_reg, chan_reg[bzc_pkg::RATE_BIT]})
      3'h0: set_next.rate = bzc_pkg::RATE_64; // see R3
      3'h1: set_next.rate = bzc_pkg::RATE_32; // see R3
      3'h2: set_next.rate = bzc_pkg::RATE_62P50; // see R4
      3'h3: set_next.rate = bzc_pkg::RATE_31P25; // see R4
      3'h4: set_next.rate = bzc_pkg::RATE_50; // see R5
      3'h5: set_next.rate = bzc_pkg::RATE_25; // see R5
      3'h6: set_next.rate = bzc_pkg::RATE_49P95; // see R6
      default: set_next.rate = bzc_pkg::RATE_24P98; // see R6
    endcase
    set_next.ahpf_code   = chan_reg[bzc_pkg::AHPF_LSB +: 3];
    set_next.ahpf_bypass = chan_reg[bzc_pkg::AHPF_LSB + 2] && chan_reg[bzc_pkg::AHPF_LSB + 1]; // see R7
    set_next.external_bias_select = chan_reg[bzc_pkg::EXTB_BIT]; // see R8
    set_next.amp_low_noise_select = chan_reg[bzc_pkg::LNA_BIT]; // see R9
    case (chan_reg[bzc_pkg::GAIN_LSB +: 2])
      2'h0:    set_next.gain_vv = 7'h0a; // see R10
      2'h1:    set_next.gain_vv = 7'h14;
      2'h2:    set_next.gain_vv = 7'h28;
      default: set_next.gain_vv = 7'h50;
    endcase
    // 0 bypass, 1 = 0.05 Hz, 2 = 0.50 Hz
    set_next.dhpf_mode = chan_reg[bzc_pkg::DHPF_LSB + 1] ? 2'h2 :
                         {1'b0, chan_reg[bzc_pkg::DHPF_LSB]}; // see R11
    if (bist_on) begin // see R15
      case (rnom)
        3'h0:    set_next.nominal_ohms = 13'h1388; // see R12
        3'h1:    set_next.nominal_ohms = 13'h09c4;
        3'h2:    set_next.nominal_ohms = 13'h0683;
        3'h3:    set_next.nominal_ohms = 13'h04e2;
        3'h4:    set_next.nominal_ohms = 13'h03e8;
        3'h5:    set_next.nominal_ohms = 13'h0341;
        3'h6:    set_next.nominal_ohms = 13'h02ca;
        default: set_next.nominal_ohms = 13'h0271;
      endcase
      set_next.nominal_switch_set = (rnom >= 3'h3); // see R13
      // Modulation: 000/001 always, 010 only for low nominal codes
      set_next.modulation_active = !rmod[2] &&
        (rmod[1] ? (!rmod[0] && rnom < 3'h3) : 1'b1); // see R13
      set_next.modulation_switch_set = set_next.modulation_active ? rmod : 3'h4; // see R12
    end else begin
      set_next.modulation_switch_set = 3'h4;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_reg <= '0;
    end else begin
      set_reg <= set_next;
    end
  end

  assign pready        = pready_reg;
  assign prdata        = prdata_reg;
  assign pslverr       = pslverr_reg;
  assign settings      = set_reg;
  assign resync_needed = resync_reg;

  // ******************************************************
  // Checks
  // ******************************************************
  a_chan_write_lands: assert property (@(posedge pclk) disable iff (!presetn) // see R1
    wr && paddr == bzc_pkg::CHAN_CFG_ADDR |=> chan_reg == ($past(pwdata[23:0]) & bzc_pkg::CHAN_CFG_WMASK))
    else $error("channel config write lost");
  a_resync_set: assert property (@(posedge pclk) disable iff (!presetn) // see R2
    wr && paddr == bzc_pkg::CHAN_CFG_ADDR |=> resync_reg)
    else $error("resync flag not raised");
  a_rate_slow: assert property (@(posedge pclk) disable iff (!presetn) // see R3
    mclk_reg == 2'h0 && chan_reg[bzc_pkg::RATE_BIT] && $stable(chan_reg) && $stable(mclk_reg)
    |=> settings.rate == bzc_pkg::RATE_32)
    else $error("rate decode wrong");
  a_rate_c11: assert property (@(posedge pclk) disable iff (!presetn) // see R6
    mclk_reg == 2'h3 && !chan_reg[bzc_pkg::RATE_BIT] && $stable(chan_reg) && $stable(mclk_reg)
    |=> settings.rate == bzc_pkg::RATE_49P95)
    else $error("rate decode wrong at 11");
  a_ahpf_bypass: assert property (@(posedge pclk) disable iff (!presetn) // see R7
    chan_reg[22:21] == 2'h3 |=> settings.ahpf_bypass || $past(chan_reg[22:21]) != 2'h3)
    else $error("ahpf bypass missing");
  a_gain_max: assert property (@(posedge pclk) disable iff (!presetn) // see R10
    $stable(chan_reg) && chan_reg[17:16] == 2'h3 |=> settings.gain_vv == 7'h50)
    else $error("gain decode wrong");
  a_rmod_no_reserved: assert property (@(posedge pclk) disable iff (!presetn) // see R14
    rmod != bzc_pkg::RMOD_RESERVED)
    else $error("reserved modulation code stored");
  a_mod_high_nom: assert property (@(posedge pclk) disable iff (!presetn) // see R13
    $stable(mux_reg) && bist_on && rnom >= 3'h3 && rmod == 3'h2 |=> !settings.modulation_active)
    else $error("modulation 010 allowed at high nominal");
  a_bist_gate: assert property (@(posedge pclk) disable iff (!presetn) // see R15
    $stable(mux_reg) && !bist_on |=> settings.nominal_ohms == 13'h0)
    else $error("nominal applied without self-test");

  // ******************************************************
  // Checks: bus access
  // ******************************************************
  a_ready_follows: assert property (@(posedge pclk) disable iff (!presetn) // see R1
    psel && !penable
    |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (@(posedge pclk) disable iff (!presetn) // see R1
    pready
    |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn) // see R1
    pslverr
    |-> pready)
    else $error("slave error without ready");
  a_unmapped_keeps: assert property (@(posedge pclk) disable iff (!presetn) // see R1
    wr && paddr != bzc_pkg::CHAN_CFG_ADDR && paddr != bzc_pkg::MUX_CFG_ADDR
    && paddr != bzc_pkg::MCLK_SEL_ADDR && paddr != bzc_pkg::RESYNC_ADDR
    |=> $stable(chan_reg) && $stable(mux_reg) && $stable(mclk_reg) && $stable(resync_reg))
    else $error("unmapped write changed state");
  a_mux_write_lands: assert property (@(posedge pclk) disable iff (!presetn) // see R15
    wr && paddr == bzc_pkg::MUX_CFG_ADDR
    && pwdata[bzc_pkg::RMOD_LSB +: 3] != bzc_pkg::RMOD_RESERVED
    |=> mux_reg == ($past(pwdata[23:0]) & bzc_pkg::MUX_CFG_WMASK))
    else $error("mux config write lost");
  a_reserved_kept: assert property (@(posedge pclk) disable iff (!presetn) // see R14
    wr && paddr == bzc_pkg::MUX_CFG_ADDR
    && pwdata[bzc_pkg::RMOD_LSB +: 3] == bzc_pkg::RMOD_RESERVED |=> rmod == $past(rmod))
    else $error("reserved modulation code changed field");
  a_resync_clear: assert property (@(posedge pclk) disable iff (!presetn) // see R2
    wr && paddr == bzc_pkg::RESYNC_ADDR && pwdata[0]
    |=> !resync_reg)
    else $error("resync command did not clear flag");

  // ******************************************************
  // Checks: decoded settings and reset defaults
  // ******************************************************
  a_rate_c01: assert property (@(posedge pclk) disable iff (!presetn) // see R4
    mclk_reg == 2'h1 && chan_reg[bzc_pkg::RATE_BIT]
    |=> settings.rate == bzc_pkg::RATE_31P25)
    else $error("rate decode wrong at 01");
  a_rate_c10: assert property (@(posedge pclk) disable iff (!presetn) // see R5
    mclk_reg == 2'h2 && !chan_reg[bzc_pkg::RATE_BIT]
    |=> settings.rate == bzc_pkg::RATE_50)
    else $error("rate decode wrong at 10");
  a_rate_c11_slow: assert property (@(posedge pclk) disable iff (!presetn) // see R6
    mclk_reg == 2'h3 && chan_reg[bzc_pkg::RATE_BIT]
    |=> settings.rate == bzc_pkg::RATE_24P98)
    else $error("slow rate decode wrong at 11");
  a_bias_follows: assert property (@(posedge pclk) disable iff (!presetn) // see R8
    1'b1
    |=> settings.external_bias_select == $past(chan_reg[bzc_pkg::EXTB_BIT]))
    else $error("bias select not followed");
  a_noise_follows: assert property (@(posedge pclk) disable iff (!presetn) // see R9
    1'b1
    |=> settings.amp_low_noise_select == $past(chan_reg[bzc_pkg::LNA_BIT]))
    else $error("amplifier mode not followed");
  a_gain_low: assert property (@(posedge pclk) disable iff (!presetn) // see R10
    chan_reg[bzc_pkg::GAIN_LSB +: 2] == 2'h1
    |=> settings.gain_vv == 7'h14)
    else $error("gain decode wrong at 01");
  a_dhpf_slow: assert property (@(posedge pclk) disable iff (!presetn) // see R11
    chan_reg[bzc_pkg::DHPF_LSB + 1]
    |=> settings.dhpf_mode == 2'h2)
    else $error("digital high-pass 1x wrong");
  a_dhpf_bypass: assert property (@(posedge pclk) disable iff (!presetn) // see R11
    chan_reg[bzc_pkg::DHPF_LSB +: 2] == 2'h0
    |=> settings.dhpf_mode == 2'h0)
    else $error("digital high-pass bypass wrong");
  a_nominal_max: assert property (@(posedge pclk) disable iff (!presetn) // see R12
    bist_on && rnom == 3'h0
    |=> settings.nominal_ohms == 13'h1388)
    else $error("largest nominal resistance wrong");
  a_unmod_high: assert property (@(posedge pclk) disable iff (!presetn) // see R12
    bist_on && rmod[2]
    |=> settings.modulation_switch_set == 3'h4 && !settings.modulation_active)
    else $error("modulation present for code 1xx");
  a_nom_switch: assert property (@(posedge pclk) disable iff (!presetn) // see R13
    bist_on && rnom >= 3'h3
    |=> settings.nominal_switch_set)
    else $error("extra nominal switches not engaged");
  a_reset_defaults: assert property (@(posedge pclk) disable iff (!presetn) // see R16
    $rose(presetn)
    |-> chan_reg == bzc_pkg::CHAN_CFG_RST && mux_reg == bzc_pkg::MUX_CFG_RST
        && mclk_reg == bzc_pkg::MCLK_SEL_RST && !resync_reg)
    else $error("register not at default after reset");
endmodule // bzc_channel_config

// [core/bzc_pkg.sv]
// Purpose: Shared constants and types for the impedance channel configuration bank
// Assumes: APB slave, 32-bit data, byte addresses as printed
// Notes:   Field positions and reset values named once here
package bzc_pkg;
  // ******************************************************
  // Register map
  // ******************************************************
  localparam logic [7:0]  CHAN_CFG_ADDR  = 8'h18;
  localparam logic [7:0]  MUX_CFG_ADDR   = 8'h17;
  localparam logic [7:0]  RESYNC_ADDR    = 8'h09;
  localparam logic [7:0]  MCLK_SEL_ADDR  = 8'h10;
  // ******************************************************
  // Field positions and resets
  // ******************************************************
  localparam int          RATE_BIT       = 23;
  localparam int          AHPF_LSB       = 20;
  localparam int          EXTB_BIT       = 19;
  localparam int          LNA_BIT        = 18;
  localparam int          GAIN_LSB       = 16;
  localparam int          DHPF_LSB       = 14;
  localparam int          RNOM_LSB       = 8;
  localparam int          RMOD_LSB       = 4;
  localparam int          BIST_BIT       = 11;
  localparam logic [23:0] CHAN_CFG_RST   = 24'h200000;
  localparam logic [23:0] CHAN_CFG_WMASK = 24'hffc000;
  localparam logic [23:0] MUX_CFG_RST    = 24'h000040;
  localparam logic [23:0] MUX_CFG_WMASK  = 24'h000f70;
  localparam logic [1:0]  MCLK_SEL_RST   = 2'h0;
  localparam logic [2:0]  RMOD_RESERVED  = 3'h3;
  // ******************************************************
  // Decoded settings carrier
  // ******************************************************
  typedef enum logic [3:0] {
    RATE_64, RATE_32, RATE_62P50, RATE_31P25, RATE_50, RATE_25, RATE_49P95, RATE_24P98
  } bzc_rate_t;
  typedef struct packed {
    bzc_rate_t   rate;
    logic [2:0]  ahpf_code;
    logic        ahpf_bypass;
    logic        external_bias_select;
    logic        amp_low_noise_select;
    logic [6:0]  gain_vv;
    logic [1:0]  dhpf_mode;
    logic [12:0] nominal_ohms;
    logic        nominal_switch_set;
    logic [2:0]  modulation_switch_set;
    logic        modulation_active;
  } bzc_settings_t;
endpackage

// [test/bzc_channel_config_tb.sv]
// Purpose: Self-checking bench for the impedance channel configuration bank
// Assumes: Zero wait-state APB slave, settings follow register one cycle later
// Notes:   No checker file; assertions live beside the design logic
`timescale 1ns/100ps
module bzc_channel_config_tb;
  logic                  pclk, presetn, psel, penable, pwrite;
  logic [7:0]            paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic                  pready, pslverr, resync_needed;
  bzc_pkg::bzc_settings_t settings;
  int                    n_mismatch, cmp_count;
  int                    nom_ohms [8] = '{5000, 2500, 1667, 1250, 1000, 833, 714, 625};

  bzc_channel_config dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .settings(settings), .resync_needed(resync_needed));

  always #5 pclk = ~pclk;

  // ******************************************************
  // Shared tasks
  // ******************************************************
  task automatic final_report();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; holds request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic err_exp);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      n_mismatch++;
      $display("MISMATCH t=%0t no ready", $time);
      final_report();
    end
    rd = prdata;
    chk(pslverr, err_exp, "slave error");
    psel <= 1'b0;
    penable <= 1'b0;
    // Write lands at the access edge, settings one edge later
    repeat (2) @(posedge pclk);
  endtask

  // ******************************************************
  // Scenarios
  // ******************************************************
  task automatic t_reset();
    chk(settings.rate, bzc_pkg::RATE_64, "rate default");
    chk(settings.ahpf_code, 3'h2, "ahpf default");
    chk(settings.gain_vv, 7'd10, "gain default");
    chk(settings.modulation_switch_set, 3'h4, "mod default");
    chk({settings.external_bias_select, settings.amp_low_noise_select}, 0, "bits");
    apb(0, bzc_pkg::CHAN_CFG_ADDR, 0, 0);
    chk(rd, 32'h00200000, "chan reset");
    apb(0, bzc_pkg::MUX_CFG_ADDR, 0, 0);
    chk(rd, 32'h00000040, "mux reset");
  endtask

  task automatic t_rates();
    for (int m = 0; m < 4; m++) begin
      for (int r = 0; r < 2; r++) begin
        apb(1, bzc_pkg::MCLK_SEL_ADDR, 32'(m), 0);
        apb(1, bzc_pkg::CHAN_CFG_ADDR, 32'(r) << 23 | 32'h00200000, 0);
        chk(settings.rate, 32'(m * 2 + r), "rate");
      end
    end
  endtask

  task automatic t_fields();
    logic [31:0] v;
    for (int i = 0; i < 8; i++) begin
      v = 32'(i) << 20 | 32'(i % 2) << 19 | 32'(i / 2 % 2) << 18 | 32'(i % 4) << 16
        | 32'((i + 1) % 4) << 14 | 32'h00001fff;
      apb(1, bzc_pkg::CHAN_CFG_ADDR, v, 0);
      apb(0, bzc_pkg::CHAN_CFG_ADDR, 0, 0);
      chk(rd, v & 32'h00ffc000, "chan readback");
      chk(settings.ahpf_code, 32'(i), "ahpf code");
      chk(settings.ahpf_bypass, 32'(i >= 6), "ahpf bypass");
      chk(settings.external_bias_select, 32'(i % 2), "bias");
      chk(settings.amp_low_noise_select, 32'(i / 2 % 2), "low noise");
      chk(settings.gain_vv, 32'(10 << (i % 4)), "gain");
      chk(settings.dhpf_mode, ((i + 1) % 4 >= 2) ? 2 : (i + 1) % 4, "dhpf");
    end
  endtask

  task automatic t_selftest();
    for (int n = 0; n < 8; n++) begin
      for (int m = 0; m < 5; m++) begin
        if (m == 3) continue;
        apb(1, bzc_pkg::MUX_CFG_ADDR, 32'h800 | 32'(n) << 8 | 32'(m) << 4, 0);
        chk(settings.nominal_ohms, 32'(nom_ohms[n]), "nominal");
        chk(settings.nominal_switch_set, 32'(n >= 3), "nom switch");
        chk(settings.modulation_active, 32'(m < 2 || (m == 2 && n < 3)), "mod");
        chk(settings.modulation_switch_set, 32'(m < 2 || (m == 2 && n < 3) ? m : 4),
            "mod switch");
      end
    end
    apb(1, bzc_pkg::MUX_CFG_ADDR, 32'h800 | 32'h10, 0);
    apb(1, bzc_pkg::MUX_CFG_ADDR, 32'h800 | 32'h530, 0);
    apb(0, bzc_pkg::MUX_CFG_ADDR, 0, 0);
    chk(rd, 32'h00000d10, "reserved mod");
    apb(1, bzc_pkg::MUX_CFG_ADDR, 32'h00000510, 0);
    chk({settings.nominal_ohms, settings.nominal_switch_set, settings.modulation_active}, 0,
        "self-test off");
    chk(settings.modulation_switch_set, 3'h4, "mod off");
  endtask

  task automatic t_resync_unmapped();
    apb(1, bzc_pkg::RESYNC_ADDR, 32'h1, 0);
    chk(resync_needed, 0, "resync clear");
    apb(1, bzc_pkg::CHAN_CFG_ADDR, 32'h00200000, 0);
    apb(0, bzc_pkg::RESYNC_ADDR, 0, 0);
    chk({resync_needed, rd[0]}, 2'b11, "resync set");
    apb(1, bzc_pkg::RESYNC_ADDR, 32'h1, 0);
    chk(resync_needed, 0, "resync done");
    apb(1, 8'h40, 32'hffffffff, 1);
    apb(0, 8'h40, 0, 1);
    chk(rd, 0, "unmapped data");
    apb(0, bzc_pkg::CHAN_CFG_ADDR, 0, 0);
    chk(rd, 32'h00200000, "unmapped no write");
  endtask

  task automatic t_mid_reset();
    apb(1, bzc_pkg::CHAN_CFG_ADDR, 32'h00ffc000, 0);
    apb(1, bzc_pkg::MCLK_SEL_ADDR, 32'h3, 0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(settings.rate, bzc_pkg::RATE_64, "rate after reset");
    chk(resync_needed, 0, "resync after reset");
    apb(0, bzc_pkg::CHAN_CFG_ADDR, 0, 0);
    chk(rd, 32'h00200000, "chan after reset");
    apb(0, bzc_pkg::MUX_CFG_ADDR, 0, 0);
    chk(rd, 32'h00000040, "mux after reset");
  endtask

  // ******************************************************
  // Main sequence
  // ******************************************************
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; n_mismatch = 0; cmp_count = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset();
    t_rates();
    t_fields();
    t_selftest();
    t_resync_unmapped();
    t_mid_reset();
    final_report();
  end
endmodule // bzc_channel_config_tb
